// ==== hw/pbc_phy_regs.v ====
/*
  Basic control and status registers of the PHY unit, reached through the
  management data interface as a register index with read and write
  strobes. Drives PHY control levels from the control register.
  Assumes the management frame engine sits outside and issues one-cycle
  strobes synchronous to clk; PHY condition inputs are synchronous too.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pbc_regs.vh"

// Functional notes
// R1 - Registers reached via management data interface
// R2 - Reset bit restores defaults, then self-clears
// R3 - Reset bit reads one while reset runs
// R4 - Loopback routes transmit back, isolates receive
// R5 - Loopback entry gives receive dead interval
// R6 - Configuration loopback overrides register loopback
// R7 - Speed bit picks 100 or 10 manually
// R8 - Auto-negotiation enable ignores speed and duplex
// R9 - Power-down bit selects low-power state
// R10 - Restart bit restarts negotiation, self-clears
// R11 - Duplex bit picks full or half manually
// R12 - Single-mode duplex forced; loopback ignores duplex
// R13 - Collision test echoes transmit enable
// R14 - Agent writes zeros to reserved control bits
// R15 - Four ability bits read as ones
// R16 - Preamble suppression bit reads zero
// R17 - Negotiation complete bit follows process
// R18 - Remote fault bit reads zero
// R19 - Negotiation ability bit reads one
// R20 - Link status latches low until read
// R21 - Jabber latches high until read
// R22 - Extended capability bit reads one
// R23 - Latched bits resume tracking after read
module pbc_phy_regs #(
  parameter RESET_CYC  = `PBC_RESET_CYC,
  parameter DEAD_CYC   = `PBC_LOOP_DEAD_CYC,
  parameter FULL_ABLE  = 1,
  parameter HALF_ABLE  = 1
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Management data interface register access
  input  wire [4:0]  mgmt_addr,
  input  wire        mgmt_wr,
  input  wire        mgmt_rd,
  input  wire [15:0] mgmt_wdata,
  output reg  [15:0] mgmt_rdata,
  output reg         mgmt_rvalid,
  // Configuration loopback strap
  input  wire        cfg_loopback,
  // PHY conditions
  input  wire        an_complete,
  input  wire        link_up,
  input  wire        jabber,
  input  wire        tx_en,
  // PHY controls
  output reg         phy_loopback,
  output reg         rx_isolate,
  output reg         rx_dead,
  output reg         speed_100,
  output reg         full_duplex,
  output reg         an_enable,
  output reg         an_restart,
  output reg         power_down,
  output reg         col_force,
  output reg         phy_soft_rst
);

  localparam CW = 16;

  // Control storage
  reg [CW-1:0] ctl_r;
  reg [CW-1:0] ctl_nxt;
  reg [7:0]    rst_cnt_r;
  reg [7:0]    rst_cnt_nxt;
  reg [7:0]    dead_cnt_r;
  reg          loop_prev_r;
  reg          rd_stat_r;

  wire         in_reset;
  wire         loop_eff;
  wire         link_ll;
  wire         jab_lh;
  wire [CW-1:0] status_w;

  // Decode one register index
  function hit;
    input [4:0] a;
    input [4:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign in_reset = (rst_cnt_r != 8'h00);
  // Strap wins, so a board forced into loopback stays there
  assign loop_eff = cfg_loopback | ctl_r[`PBC_CTL_LOOP_BIT]; // see R6

  // Control register write and self-clearing bits
  always @* begin
    ctl_nxt     = ctl_r;
    rst_cnt_nxt = rst_cnt_r;
    ctl_nxt[`PBC_CTL_ANRST_BIT] = 1'b0; // see R10
    if (in_reset) begin
      rst_cnt_nxt = rst_cnt_r - 8'h01;
      ctl_nxt     = `PBC_CTL_RESET_VAL; // see R2
      ctl_nxt[`PBC_CTL_RESET_BIT] = (rst_cnt_r != 8'h01); // see R3
    end else if (mgmt_wr && hit(mgmt_addr, `PBC_ADDR_CONTROL)) begin // see R1
      ctl_nxt = mgmt_wdata;
      // Reserved bits kept zero whatever the agent sends
      ctl_nxt[`PBC_CTL_RSVD10_BIT] = 1'b0; // see R14
      ctl_nxt[6:0] = 7'h00; // see R14
      // Defaults go in at once so no control output glitches
      if (mgmt_wdata[`PBC_CTL_RESET_BIT]) begin
        rst_cnt_nxt = RESET_CYC[7:0]; // see R2
        ctl_nxt     = `PBC_CTL_RESET_VAL; // see R2
        ctl_nxt[`PBC_CTL_RESET_BIT] = 1'b1; // see R3
      end
      // Single-mode PHY: duplex bit reflects the only mode
      if (FULL_ABLE == 0)
        ctl_nxt[`PBC_CTL_DUPLEX_BIT] = 1'b0; // see R12
      else if (HALF_ABLE == 0)
        ctl_nxt[`PBC_CTL_DUPLEX_BIT] = 1'b1; // see R12
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r     <= `PBC_CTL_RESET_VAL;
      rst_cnt_r <= 8'h00;
    end else begin
      ctl_r     <= ctl_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // Latched link and jabber bits, cleared by a status read
  pbc_latch_bit #(.LATCH_HIGH(0)) u_link (
    .clk      (clk),
    .rst_n    (rst_n),
    .sw_rst   (in_reset),
    .cond     (link_up),
    .rd_pulse (rd_stat_r),
    .val_r    (link_ll)
  );

  pbc_latch_bit #(.LATCH_HIGH(1)) u_jab (
    .clk      (clk),
    .rst_n    (rst_n),
    .sw_rst   (in_reset),
    .cond     (jabber),
    .rd_pulse (rd_stat_r),
    .val_r    (jab_lh)
  );

  // Status word assembly
  assign status_w = `PBC_STS_CAP_MASK // see R15
    | {9'h000, 1'b0, // see R16
       an_complete & ~in_reset, // see R17
       1'b0, // see R18
       1'b1, // see R19
       link_ll, jab_lh,
       1'b1}; // see R22

  // Read path; status read clears latches the cycle after data is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
      rd_stat_r   <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      rd_stat_r   <= mgmt_rd && hit(mgmt_addr, `PBC_ADDR_STATUS);
      if (mgmt_rd) begin
        if (hit(mgmt_addr, `PBC_ADDR_CONTROL))
          mgmt_rdata <= ctl_r; // see R3
        else if (hit(mgmt_addr, `PBC_ADDR_STATUS))
          mgmt_rdata <= status_w; // see R20 see R21
        else
          mgmt_rdata <= 16'h0000;
      end
    end
  end

  // Receive dead interval after entering loopback
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_prev_r <= 1'b0;
      dead_cnt_r  <= 8'h00;
    end else begin
      loop_prev_r <= loop_eff;
      if (loop_eff && !loop_prev_r)
        dead_cnt_r <= DEAD_CYC[7:0]; // see R5
      else if (dead_cnt_r != 8'h00)
        dead_cnt_r <= dead_cnt_r - 8'h01;
    end
  end

  // PHY control levels, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_loopback <= 1'b0;
      rx_isolate   <= 1'b0;
      rx_dead      <= 1'b0;
      speed_100    <= 1'b1;
      full_duplex  <= 1'b0;
      an_enable    <= 1'b1;
      an_restart   <= 1'b0;
      power_down   <= 1'b0;
      col_force    <= 1'b0;
      phy_soft_rst <= 1'b0;
    end else begin
      phy_loopback <= loop_eff; // see R4
      rx_isolate   <= loop_eff; // see R4
      rx_dead      <= (dead_cnt_r != 8'h00) || (loop_eff && !loop_prev_r);
      an_enable    <= ctl_r[`PBC_CTL_ANEN_BIT]; // see R8
      an_restart   <= ctl_r[`PBC_CTL_ANRST_BIT]; // see R10
      power_down   <= ctl_r[`PBC_CTL_PDOWN_BIT]; // see R9
      col_force    <= ctl_r[`PBC_CTL_COLT_BIT] & tx_en; // see R13
      phy_soft_rst <= in_reset; // see R2
      // Manual speed and duplex only when negotiation is off
      if (!ctl_r[`PBC_CTL_ANEN_BIT]) begin
        speed_100 <= ctl_r[`PBC_CTL_SPEED_BIT]; // see R7 see R8
        // Loopback forces full duplex so the bit has no effect
        full_duplex <= loop_eff | ctl_r[`PBC_CTL_DUPLEX_BIT]; // see R11 see R12
      end else begin
        speed_100   <= 1'b1;
        full_duplex <= loop_eff;
      end
    end
  end

endmodule // pbc_phy_regs

`default_nettype wire

// ==== hw/pbc_regs.vh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  PHY basic control and status register pair.
  Assumes it is included by bare name from design files; definitions only.
*/
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

// Register indices on the management data interface
`define PBC_ADDR_CONTROL     5'h00
`define PBC_ADDR_STATUS      5'h01

// Control register fields
`define PBC_CTL_RESET_BIT    15
`define PBC_CTL_LOOP_BIT     14
`define PBC_CTL_SPEED_BIT    13
`define PBC_CTL_ANEN_BIT     12
`define PBC_CTL_PDOWN_BIT    11
`define PBC_CTL_RSVD10_BIT   10
`define PBC_CTL_ANRST_BIT    9
`define PBC_CTL_DUPLEX_BIT   8
`define PBC_CTL_COLT_BIT     7

// Control reset value: speed 100 and auto-negotiation on
`define PBC_CTL_RESET_VAL    16'h3000

// Status register fields
`define PBC_STS_CAP_MASK     16'h7800
`define PBC_STS_PREAMB_BIT   6
`define PBC_STS_ANDONE_BIT   5
`define PBC_STS_RFAULT_BIT   4
`define PBC_STS_ANABLE_BIT   3
`define PBC_STS_LINK_BIT     2
`define PBC_STS_JABBER_BIT   1
`define PBC_STS_EXTCAP_BIT   0

// Dead time on the receive path after loopback entry
`define PBC_LOOP_DEAD_NS     560
`define PBC_CLK_PERIOD_NS    4
`define PBC_LOOP_DEAD_CYC    ((`PBC_LOOP_DEAD_NS + `PBC_CLK_PERIOD_NS - 1) / `PBC_CLK_PERIOD_NS)

// Length of the internal reset sequence, in clock cycles
`define PBC_RESET_CYC        16

`endif

// ==== hw/pbc_latch_bit.v ====
/*
  One latched status bit: latching low or latching high, selected by
  a parameter. Holds the caught value until the status register is read.
  Assumes cond is synchronous to clk and rd_pulse is one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none

module pbc_latch_bit #(
  parameter LATCH_HIGH = 0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  input  wire sw_rst,
  // Condition and read strobe
  input  wire cond,
  input  wire rd_pulse,
  // Latched value
  output reg  val_r
);

  reg val_nxt;

  // Event beats the read clear so nothing is lost on the read cycle
  always @* begin
    val_nxt = val_r;
    if (LATCH_HIGH != 0) begin
      if (cond)
        val_nxt = 1'b1;
      else if (rd_pulse)
        val_nxt = 1'b0; // see R23
    end else begin
      if (!cond)
        val_nxt = 1'b0;
      else if (rd_pulse)
        val_nxt = 1'b1; // see R23
    end
  end

  // Default after reset is zero for both kinds
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      val_r <= 1'b0;
    else if (sw_rst)
      val_r <= 1'b0;
    else
      val_r <= val_nxt; // see R20 see R21
  end

endmodule // pbc_latch_bit

`default_nettype wire

// ==== test/pbc_phy_regs_props.sv ====
/* Checker for the PHY basic register pair, watching top-level ports only.
   Assumes binding onto pbc_phy_regs, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module pbc_phy_regs_chk (
  // Clock, reset and access
  input wire        clk, rst_n, mgmt_rd, mgmt_rvalid,
  input wire [4:0]  mgmt_addr,
  input wire [15:0] mgmt_rdata,
  // Levels in and out
  input wire cfg_loopback, tx_en, phy_loopback, rx_isolate, rx_dead,
  input wire speed_100, full_duplex, an_enable, an_restart, col_force
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read answer comes exactly one cycle after the strobe
  chk_rd_answer: assert property (mgmt_rd |=> mgmt_rvalid) else $error("no read answer");
  chk_no_spur: assert property (mgmt_rvalid |-> $past(mgmt_rd)) else $error("spurious answer");
  chk_sts_const: assert property (mgmt_rvalid && $past(mgmt_addr) == 5'h01 |-> (mgmt_rdata & 16'h7859) == 16'h7809) else $error("status constants wrong");
  chk_cfg_loop: assert property (cfg_loopback |=> phy_loopback) else $error("strap loopback lost");
  chk_iso_loop: assert property (rx_isolate == phy_loopback) else $error("isolate differs");
  chk_dead_time: assert property ($rose(phy_loopback) |=> rx_dead) else $error("no dead time");
  chk_col_cause: assert property (col_force |-> $past(tx_en)) else $error("collision without tx_en");
  chk_an_speed: assert property (an_enable |-> speed_100) else $error("speed not ignored");
  chk_rst_pulse: assert property (an_restart |=> !an_restart) else $error("restart not a pulse");
  chk_loop_dup: assert property (phy_loopback |-> full_duplex) else $error("duplex used in loopback");
  cover property (mgmt_rvalid && mgmt_rdata[15]);
  cover property ($rose(phy_loopback));
  cover property (col_force);
endmodule // pbc_phy_regs_chk
`default_nettype wire

// ==== test/pbc_agent.sv ====
/* Management agent model issuing one-cycle register strobes.
   Assumes the block answers one cycle after a read strobe. */
`timescale 1ns/1ps
`default_nettype none
module pbc_agent (
  // Clock and answer
  input  wire       clk,
  input  wire [15:0] rdata,
  input  wire       rvalid,
  // Requests
  output logic [4:0] addr,
  output logic      wr,
  output logic      rd,
  output logic [15:0] wdata
);
  initial begin
    addr = 5'h00; wr = 1'b0; rd = 1'b0; wdata = 16'h0000;
  end
  // Strobe held for one edge, data qualified with it
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk); #1 addr = a; wdata = d; wr = 1'b1;
    @(posedge clk); #1 wr = 1'b0; wdata = ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk); #1 addr = a; rd = 1'b1;
    @(posedge clk); #1 rd = 1'b0;
    q = rvalid ? rdata : 16'hDEAD;
  endtask
  // Poll until reset bit clears before further traffic
  task automatic wait_rst();
    logic [15:0] q;
    q = 16'hFFFF;
    for (int i = 0; i < 40 && q[15] !== 1'b0; i++) rd_reg(5'h00, q);
  endtask
endmodule // pbc_agent
`default_nettype wire

// ==== test/tb_phy_basic_control_status_regs.sv ====
/* Self-checking bench for the PHY basic register pair.
   Assumes pbc_agent drives the access port; 4 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_basic_control_status_regs;
  logic clk, rst_n, cfg_loopback, an_complete, link_up, jabber, tx_en;
  logic [4:0] addr; logic wr, rd; logic [15:0] wdata, rdata, q;
  logic rvalid, lp, iso, dead, spd, fd, ane, anr, pd, col, srst;
  int fail_count = 0;
  int tests_run = 0;
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  pbc_agent u_ag (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr),
    .wr(wr), .rd(rd), .wdata(wdata));
  pbc_phy_regs DUT (.clk(clk), .rst_n(rst_n), .mgmt_addr(addr),
    .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wdata), .mgmt_rdata(rdata),
    .mgmt_rvalid(rvalid), .cfg_loopback(cfg_loopback),
    .an_complete(an_complete), .link_up(link_up), .jabber(jabber),
    .tx_en(tx_en), .phy_loopback(lp), .rx_isolate(iso), .rx_dead(dead),
    .speed_100(spd), .full_duplex(fd), .an_enable(ane), .an_restart(anr),
    .power_down(pd), .col_force(col), .phy_soft_rst(srst));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Pulse a condition input for two cycles
  task automatic blip(ref logic s, input logic v);
    @(posedge clk); #1 s = v; repeat (2) @(posedge clk); #1 s = ~v;
  endtask
  task automatic t_status();
    u_ag.rd_reg(5'h00, q); chk(q, 16'h3000);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h7809);
    an_complete = 1'b1;
    u_ag.rd_reg(5'h01, q); chk(q, 16'h782D);
    blip(link_up, 1'b0);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h7829);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h782D);
    blip(jabber, 1'b1);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h782F);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h782D);
  endtask
  task automatic t_ctl();
    u_ag.wr_reg(5'h00, 16'h45FF); // Reserved ones on purpose
    u_ag.rd_reg(5'h00, q); chk(q, 16'h4180);
    chk({lp, iso, spd, ane, fd}, 16'h0019);
    tx_en = 1'b1; repeat (2) @(posedge clk); #1 chk(col, 1'b1);
    tx_en = 1'b0;
    u_ag.rd_reg(5'h05, q); chk(q, 16'h0000);
    u_ag.wr_reg(5'h00, 16'h0800); repeat (2) @(posedge clk); #1
    chk({pd, spd, fd, lp}, 16'h0008);
    cfg_loopback = 1'b1; repeat (2) @(posedge clk); #1 chk(lp, 1'b1);
    cfg_loopback = 1'b0;
    u_ag.wr_reg(5'h00, 16'h1200);
    for (int i = 0; i < 4 && anr !== 1'b1; i++) begin @(posedge clk); #1; end
    chk(anr, 1'b1);
    u_ag.rd_reg(5'h00, q); chk(q, 16'h1000);
  endtask
  task automatic t_srst();
    u_ag.wr_reg(5'h00, 16'h8000);
    u_ag.rd_reg(5'h00, q); chk(q, 16'hB000);
    chk(srst, 1'b1);
    u_ag.wait_rst();
    chk(srst, 1'b0);
    u_ag.rd_reg(5'h00, q); chk(q, 16'h3000);
    u_ag.rd_reg(5'h01, q); chk(q, 16'h7829);
  endtask
  initial begin
    rst_n = 1'b0; cfg_loopback = 1'b0; an_complete = 1'b0;
    link_up = 1'b1; jabber = 1'b0; tx_en = 1'b0;
    repeat (3) @(posedge clk); #1 rst_n = 1'b1;
    t_status(); t_ctl(); t_srst();
    results();
  end
  // Watchdog: whole run is under a hundred cycles
  initial begin #20000 fail_count++; results(); end
endmodule // tb_phy_basic_control_status_regs
bind pbc_phy_regs pbc_phy_regs_chk u_chk (.*);
`default_nettype wire
